// *** core/csel_top.v ***
/*
 * Clock source select: five source selectors (PLL reference, DSP, DAC,
 * oversampling and charge pump dividers) programmed over AXI4-Lite (the PLL
 * reference from auto_pll_ref while auto_clock_mode is high), each
 * feeding a glitch-free switch. Assumes every source clock and pin level
 * is already synchronous to aclk and slower than half its rate.
 */
`timescale 1ns/1ps
`include "csel_consts.vh"

module csel_top #(
   parameter AW = 8
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire [AW-1:0] s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output reg           s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output reg           s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [AW-1:0] s_axi_araddr,
   input  wire          s_axi_arvalid,
   output reg           s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   input  wire          master_clk,
   input  wire          pll_clk,
   input  wire          internal_oscillator,
   input  wire          mclk,
   input  wire          sclk,
   input  wire          general_pin_zero,
   input  wire          general_pin_two,
   input  wire          auto_clock_mode,
   input  wire          auto_pll_ref,
   output wire          pll_ref_clk,
   output wire          dsp_div_clk,
   output wire          dac_div_clk,
   output wire          osr_div_clk,
   output wire          cp_div_clk
);

   // -------------------------------------------------------------------
   // Source index decode helpers
   // -------------------------------------------------------------------

   // Codes 0..5 of the DAC style map straight to the source vector
   function [2:0] map_dac;
      input [2:0] code;
      begin
         if (code <= 3'h5)
            map_dac = code;
         else
            map_dac = `CSEL_SRC_MUTE;
      end
   endfunction

   // OSR style: 0 is the DAC clock, 1..6 shift down onto the vector
   function [2:0] map_osr;
      input [2:0] code;
      begin
         if (code == 3'h0)
            map_osr = `CSEL_SRC_DAC;
         else if (code <= 3'h6)
            map_osr = code - 3'h1;
         else
            map_osr = `CSEL_SRC_MUTE;
      end
   endfunction

   // Pin field is valid only for the two documented pin codes
   function pin_ok;
      input [2:0] code;
      begin
         pin_ok = (code == `CSEL_PIN_ZERO) || (code == `CSEL_PIN_TWO);
      end
   endfunction

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   reg  [7:0]  pll_and_dsp_clock_source;
   reg  [7:0]  dac_and_osr_clock_source;
   reg  [7:0]  charge_pump_clock_source;
   reg  [7:0]  dsp_dac_gpio_clock_pin;
   reg  [7:0]  cp_osr_gpio_clock_pin;

   wire        pll_ref_select;
   wire [2:0]  dsp_divider_source;
   wire [2:0]  dac_divider_source;
   wire [2:0]  oversample_divider_source;
   wire [2:0]  charge_pump_divider_source;
   wire [2:0]  dsp_clock_pin_select;
   wire [2:0]  dac_clock_pin_select;
   wire [2:0]  charge_pump_clock_pin_select;
   wire [2:0]  oversample_clock_pin_select;

   assign pll_ref_select = pll_and_dsp_clock_source[`CSEL_POS_PLL_REF];
   assign dsp_divider_source =
      pll_and_dsp_clock_source[`CSEL_POS_DSP_SRC +: 3];
   assign dac_divider_source =
      dac_and_osr_clock_source[`CSEL_POS_DAC_SRC +: 3];
   assign oversample_divider_source =
      dac_and_osr_clock_source[`CSEL_POS_OSR_SRC +: 3];
   assign charge_pump_divider_source =
      charge_pump_clock_source[`CSEL_POS_CP_SRC +: 3];
   assign dsp_clock_pin_select =
      dsp_dac_gpio_clock_pin[`CSEL_POS_DSP_PIN +: 3];
   assign dac_clock_pin_select =
      dsp_dac_gpio_clock_pin[`CSEL_POS_DAC_PIN +: 3];
   assign charge_pump_clock_pin_select =
      cp_osr_gpio_clock_pin[`CSEL_POS_CP_PIN +: 3];
   assign oversample_clock_pin_select =
      cp_osr_gpio_clock_pin[`CSEL_POS_OSR_PIN +: 3];

   // -------------------------------------------------------------------
   // Source vectors and selections per channel
   // -------------------------------------------------------------------
   // Channel order: 0 PLL ref, 1 DSP, 2 DAC, 3 OSR, 4 CP
   wire [4:0]  ch_clk;
   wire [4:0]  ch_run;
   wire [4:0]  ch_sw;
   wire [39:0] ch_src;
   reg  [14:0] ch_sel;
   wire [4:0]  pin_lvl;
   wire [4:0]  pin_val;

   assign pin_lvl[1] = (dsp_clock_pin_select == `CSEL_PIN_TWO) ?
                       general_pin_two : general_pin_zero;
   assign pin_val[1] = pin_ok(dsp_clock_pin_select);
   assign pin_lvl[2] = (dac_clock_pin_select == `CSEL_PIN_TWO) ?
                       general_pin_two : general_pin_zero;
   assign pin_val[2] = pin_ok(dac_clock_pin_select);
   assign pin_lvl[3] = (oversample_clock_pin_select == `CSEL_PIN_TWO) ?
                       general_pin_two : general_pin_zero;
   assign pin_val[3] = pin_ok(oversample_clock_pin_select);
   assign pin_lvl[4] = (charge_pump_clock_pin_select == `CSEL_PIN_TWO) ?
                       general_pin_two : general_pin_zero;
   assign pin_val[4] = pin_ok(charge_pump_clock_pin_select);
   // PLL reference has no pin choice here
   assign pin_lvl[0] = 1'b0;
   assign pin_val[0] = 1'b0;

   // Selection decode; a GPIO choice with an unusable pin is muted
   always @* begin
      ch_sel = {5{`CSEL_SRC_MUTE}};
      if (auto_clock_mode ? auto_pll_ref : pll_ref_select)
         ch_sel[2:0] = `CSEL_SRC_SCLK;
      else
         ch_sel[2:0] = `CSEL_SRC_MCLK;
      ch_sel[5:3] = map_dac(dsp_divider_source);
      ch_sel[8:6] = map_dac(dac_divider_source);
      ch_sel[11:9] = map_osr(oversample_divider_source);
      ch_sel[14:12] = map_osr(charge_pump_divider_source);
      if (ch_sel[5:3] == `CSEL_SRC_GPIO && !pin_val[1])
         ch_sel[5:3] = `CSEL_SRC_MUTE;
      if (ch_sel[8:6] == `CSEL_SRC_GPIO && !pin_val[2])
         ch_sel[8:6] = `CSEL_SRC_MUTE;
      if (ch_sel[11:9] == `CSEL_SRC_GPIO && !pin_val[3])
         ch_sel[11:9] = `CSEL_SRC_MUTE;
      if (ch_sel[14:12] == `CSEL_SRC_GPIO && !pin_val[4])
         ch_sel[14:12] = `CSEL_SRC_MUTE;
   end

   // One switch per channel; the DAC clock tap is the DAC switch output,
   // so OSR and CP never see a glitch from a DAC reselection
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_ch
         assign ch_src[gi*8 +: 8] = {1'b0, ch_clk[2], pin_lvl[gi], sclk,
                                     mclk, internal_oscillator, pll_clk,
                                     master_clk};
         csel_clk_switch u_sw (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .src_levels (ch_src[gi*8 +: 8]),
            .want_sel   (ch_sel[gi*3 +: 3]),
            .clk_out    (ch_clk[gi]),
            .running    (ch_run[gi]),
            .switching  (ch_sw[gi])
         );
      end
   endgenerate

   assign pll_ref_clk = ch_clk[0];
   assign dsp_div_clk = ch_clk[1];
   assign dac_div_clk = ch_clk[2];
   assign osr_div_clk = ch_clk[3];
   assign cp_div_clk  = ch_clk[4];

   // -------------------------------------------------------------------
   // AXI4-Lite write path
   // -------------------------------------------------------------------
   reg          aw_held;
   reg          w_held;
   reg [AW-1:0] aw_addr;
   reg [7:0]    w_byte;
   reg          w_en0;
   wire [5:0]   w_idx;
   wire         w_go;

   assign w_idx = aw_addr[7:2];
   assign w_go  = aw_held && w_held && !s_axi_bvalid;

   // Address and data are taken independently, in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held                  <= 1'b0;
         w_held                   <= 1'b0;
         aw_addr                  <= {AW{1'b0}};
         w_byte                   <= 8'h00;
         w_en0                    <= 1'b0;
         s_axi_awready            <= 1'b0;
         s_axi_wready             <= 1'b0;
         s_axi_bvalid             <= 1'b0;
         s_axi_bresp              <= `CSEL_RESP_OKAY;
         pll_and_dsp_clock_source <= `CSEL_RST_REG;
         dac_and_osr_clock_source <= `CSEL_RST_REG;
         charge_pump_clock_source <= `CSEL_RST_REG;
         dsp_dac_gpio_clock_pin   <= `CSEL_RST_REG;
         cp_osr_gpio_clock_pin    <= `CSEL_RST_REG;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            w_byte       <= s_axi_wdata[7:0];
            w_en0        <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (w_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `CSEL_RESP_OKAY;
            case (w_idx)
               `CSEL_IDX_PLL_DSP:
                  if (w_en0) pll_and_dsp_clock_source <= w_byte;
               `CSEL_IDX_DAC_OSR:
                  if (w_en0) dac_and_osr_clock_source <= w_byte;
               `CSEL_IDX_CP:
                  if (w_en0) charge_pump_clock_source <= w_byte;
               `CSEL_IDX_DSP_DAC_P:
                  if (w_en0) dsp_dac_gpio_clock_pin <= w_byte;
               `CSEL_IDX_CP_OSR_P:
                  if (w_en0) cp_osr_gpio_clock_pin <= w_byte;
               // Status is read only; writes to it are ignored quietly
               `CSEL_IDX_STATUS: s_axi_bresp <= `CSEL_RESP_OKAY;
               default: s_axi_bresp <= `CSEL_RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite read path
   // -------------------------------------------------------------------
   reg [31:0] next_rdata;
   reg        next_rerr;

   // Read mux; reserved register bits read back as written
   always @* begin
      next_rdata = 32'h0000_0000;
      next_rerr  = 1'b0;
      case (s_axi_araddr[7:2])
         `CSEL_IDX_PLL_DSP:   next_rdata[7:0] = pll_and_dsp_clock_source;
         `CSEL_IDX_DAC_OSR:   next_rdata[7:0] = dac_and_osr_clock_source;
         `CSEL_IDX_CP:        next_rdata[7:0] = charge_pump_clock_source;
         `CSEL_IDX_DSP_DAC_P: next_rdata[7:0] = dsp_dac_gpio_clock_pin;
         `CSEL_IDX_CP_OSR_P:  next_rdata[7:0] = cp_osr_gpio_clock_pin;
         `CSEL_IDX_STATUS:    next_rdata[12:0] = {ch_sw, 3'h0, ch_run};
         default:             next_rerr = 1'b1;
      endcase
   end

   // One read at a time; arready is a single-cycle offer
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `CSEL_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rerr ? `CSEL_RESP_SLVERR : `CSEL_RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // csel_top

// *** inc/csel_consts.vh ***
/*
 * Constants of the clock source select block: register indices, field
 * positions, reset values, source codes and the switchover settle count.
 * Assumes it is included by bare name from files under core/.
 */
`ifndef CSEL_CONSTS_VH
`define CSEL_CONSTS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CSEL_IDX_PLL_DSP    6'h0D
`define CSEL_IDX_DAC_OSR    6'h0E
`define CSEL_IDX_CP        6'h0F
`define CSEL_IDX_DSP_DAC_P 6'h10
`define CSEL_IDX_CP_OSR_P  6'h11
`define CSEL_IDX_STATUS    6'h20

// ----------------------------------------------------------------------
// Field positions (low bit of each field)
// ----------------------------------------------------------------------
`define CSEL_POS_PLL_REF   4
`define CSEL_POS_DSP_SRC   0
`define CSEL_POS_DAC_SRC   4
`define CSEL_POS_OSR_SRC   0
`define CSEL_POS_CP_SRC    0
`define CSEL_POS_DSP_PIN   4
`define CSEL_POS_DAC_PIN   0
`define CSEL_POS_CP_PIN    4
`define CSEL_POS_OSR_PIN   0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CSEL_RST_REG       8'h00

// ----------------------------------------------------------------------
// Pin selector codes
// ----------------------------------------------------------------------
`define CSEL_PIN_ZERO      3'h3
`define CSEL_PIN_TWO       3'h5

// ----------------------------------------------------------------------
// Internal source indices of the switch input vector
// ----------------------------------------------------------------------
`define CSEL_SRC_MASTER    3'h0
`define CSEL_SRC_PLL       3'h1
`define CSEL_SRC_OSC       3'h2
`define CSEL_SRC_MCLK      3'h3
`define CSEL_SRC_SCLK      3'h4
`define CSEL_SRC_GPIO      3'h5
`define CSEL_SRC_DAC       3'h6
`define CSEL_SRC_MUTE      3'h7

// ----------------------------------------------------------------------
// Timing and bus answers
// ----------------------------------------------------------------------
`define CSEL_SETTLE_CYCLES 4
`define CSEL_RESP_OKAY     2'h0
`define CSEL_RESP_SLVERR   2'h2

`endif

// *** core/csel_clk_switch.v ***
/*
 * One glitch-free clock source switch: picks one of eight source levels,
 * finishes the high phase of the old source, then holds low while the new
 * source settles. Assumes all source levels are synchronous to aclk.
 */
`timescale 1ns/1ps
`include "csel_consts.vh"

module csel_clk_switch #(
   parameter          CW     = 4,
   parameter [CW-1:0] SETTLE = `CSEL_SETTLE_CYCLES
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire [7:0]    src_levels,
   input  wire [2:0]    want_sel,
   output reg           clk_out,
   output reg           running,
   output reg           switching
);

   // -------------------------------------------------------------------
   // States
   // -------------------------------------------------------------------
   localparam [2:0] ST_RUN    = 3'b001;
   localparam [2:0] ST_DRAIN  = 3'b010;
   localparam [2:0] ST_SETTLE = 3'b100;

   reg [2:0]    state;
   reg [2:0]    cur_sel;
   reg [CW-1:0] cnt;

   // Switch sequencer; starts muted so the reset selection also settles
   always @(posedge aclk) begin
      if (!aresetn) begin
         state     <= ST_SETTLE;
         cur_sel   <= `CSEL_SRC_MUTE;
         cnt       <= {CW{1'b0}};
         clk_out   <= 1'b0;
         running   <= 1'b0;
         switching <= 1'b1;
      end else begin
         case (state)
            ST_RUN: begin
               clk_out <= src_levels[cur_sel];
               if (want_sel != cur_sel) begin
                  state     <= ST_DRAIN;
                  switching <= 1'b1;
               end
            end
            ST_DRAIN: begin
               // Let the old high phase finish before muting
               if (src_levels[cur_sel] == 1'b0) begin
                  clk_out <= 1'b0;
                  cur_sel <= want_sel;
                  cnt     <= {CW{1'b0}};
                  running <= 1'b0;
                  state   <= ST_SETTLE;
               end else begin
                  clk_out <= 1'b1;
               end
            end
            ST_SETTLE: begin
               clk_out <= 1'b0;
               if (want_sel != cur_sel) begin
                  cur_sel <= want_sel;
                  cnt     <= {CW{1'b0}};
               end else if (cnt == SETTLE - 1'b1) begin
                  state     <= ST_RUN;
                  switching <= 1'b0;
                  running   <= (cur_sel != `CSEL_SRC_MUTE);
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            default: begin
               state   <= ST_SETTLE;
               clk_out <= 1'b0;
            end
         endcase
      end
   end

endmodule // csel_clk_switch

// *** dv/csel_sva.sv ***
/*
 * Checker for csel_top: bus answer timing and divider clock outputs.
 * Assumes it is bound into csel_top and sees only that module's ports.
 */
`timescale 1ns/1ps
`include "csel_consts.vh"

module csel_sva #(
   parameter AW = 8
) (
   input wire          aclk,
   input wire          aresetn,
   input wire          s_axi_awvalid,
   input wire          s_axi_awready,
   input wire          s_axi_wvalid,
   input wire          s_axi_wready,
   input wire [1:0]    s_axi_bresp,
   input wire          s_axi_bvalid,
   input wire          s_axi_bready,
   input wire [AW-1:0] s_axi_araddr,
   input wire          s_axi_arvalid,
   input wire          s_axi_arready,
   input wire [31:0]   s_axi_rdata,
   input wire [1:0]    s_axi_rresp,
   input wire          s_axi_rvalid,
   input wire          s_axi_rready,
   input wire          master_clk,
   input wire          pll_clk,
   input wire          internal_oscillator,
   input wire          mclk,
   input wire          sclk,
   input wire          general_pin_zero,
   input wire          general_pin_two,
   input wire          pll_ref_clk,
   input wire          dsp_div_clk,
   input wire          dac_div_clk,
   input wire          osr_div_clk,
   input wire          cp_div_clk
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ---------------------------------------------------------------
   // Helper history and named steps
   // ---------------------------------------------------------------
   // Source history spans the output copy delay
   logic [2:0] ref_hist;
   always @(posedge aclk) begin
      ref_hist <= {ref_hist[1:0], mclk | sclk};
   end
   wire any_src = master_clk | pll_clk | internal_oscillator | mclk |
                  sclk | general_pin_zero | general_pin_two;
   wire any_out = pll_ref_clk | dsp_div_clk | dac_div_clk |
                  osr_div_clk | cp_div_clk;
   wire [AW-3:0] ar_idx = s_axi_araddr[AW-1:2];
   wire ar_map = ar_idx inside {`CSEL_IDX_PLL_DSP, `CSEL_IDX_DAC_OSR,
      `CSEL_IDX_CP, `CSEL_IDX_DSP_DAC_P, `CSEL_IDX_CP_OSR_P, `CSEL_IDX_STATUS};
   sequence s_quiet;
      !any_src;
   endsequence
   sequence s_ar_take(m);
      s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] == 2'b00 && ar_map == m;
   endsequence

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   AST_NO_CLK_QUIET:
   assert property (s_quiet [*3] |-> !any_out)
      else $error("Divider clock high with all sources low");
   AST_PLL_REF_SRC:
   assert property (pll_ref_clk |-> |ref_hist)
      else $error("PLL reference high without mclk or sclk");
   AST_B_CAUSE:
   assert property ($rose(s_axi_bvalid) |->
      $past(s_axi_awvalid && s_axi_awready, 2) ||
      $past(s_axi_wvalid && s_axi_wready, 2))
      else $error("Write answer without a taken address or data");
   AST_B_HOLD:
   assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write answer dropped before bready");
   AST_B_REFUSE:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("Write ready offered while answer pending");
   AST_R_ANSWER:
   assert property (s_ar_take(1'b1) or s_ar_take(1'b0) |=> s_axi_rvalid)
      else $error("Read answer late");
   AST_R_HOLD:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
      $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("Read answer changed before rready");
   AST_R_REFUSE:
   assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("Read ready offered while answer pending");
   AST_RD_UNMAPPED:
   assert property (s_ar_take(1'b0) |=>
      s_axi_rresp == `CSEL_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("Unmapped read not refused");
   AST_RD_MAPPED:
   assert property (s_ar_take(1'b1) |=>
      s_axi_rresp == `CSEL_RESP_OKAY && s_axi_rdata[31:13] == 19'h0_0000)
      else $error("Mapped read answer wrong");
endmodule // csel_sva

bind csel_top csel_sva #(.AW(AW)) i_csel_sva (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .master_clk(master_clk), .pll_clk(pll_clk),
   .internal_oscillator(internal_oscillator), .mclk(mclk), .sclk(sclk),
   .general_pin_zero(general_pin_zero), .general_pin_two(general_pin_two),
   .pll_ref_clk(pll_ref_clk), .dsp_div_clk(dsp_div_clk),
   .dac_div_clk(dac_div_clk), .osr_div_clk(osr_div_clk),
   .cp_div_clk(cp_div_clk)
);

// *** dv/csel_top_tb_top.sv ***
/*
 * Self-checking bench for csel_top: register access over AXI4-Lite and
 * routing of every selector code to the divider clock outputs.
 * Assumes the design header is on the include path.
 */
`timescale 1ns/1ps
`include "csel_consts.vh"

module csel_top_tb_top;
   localparam logic [7:0] A_PD = {`CSEL_IDX_PLL_DSP, 2'b00};
   localparam logic [7:0] A_DO = {`CSEL_IDX_DAC_OSR, 2'b00};
   localparam logic [7:0] A_CP = {`CSEL_IDX_CP, 2'b00};
   localparam logic [7:0] A_P1 = {`CSEL_IDX_DSP_DAC_P, 2'b00};
   localparam logic [7:0] A_P2 = {`CSEL_IDX_CP_OSR_P, 2'b00};
   localparam logic [1:0] OK = `CSEL_RESP_OKAY;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic [6:0]  srcs;
   logic        auto_mode, auto_ref;
   wire         awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [4:0]  outs;
   int          num_errors = 0;
   int          checked = 0;

   csel_top #(.AW(8)) i_csel_top (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .master_clk(srcs[0]),
      .pll_clk(srcs[1]), .internal_oscillator(srcs[2]), .mclk(srcs[3]),
      .sclk(srcs[4]), .general_pin_zero(srcs[5]), .general_pin_two(srcs[6]),
      .auto_clock_mode(auto_mode), .auto_pll_ref(auto_ref),
      .pll_ref_clk(outs[0]), .dsp_div_clk(outs[1]), .dac_div_clk(outs[2]),
      .osr_div_clk(outs[3]), .cp_div_clk(outs[4])
   );

   // 20 MHz bus clock
   always #25 aclk = ~aclk;

   // ---------------------------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Address and data offered together, bready held until the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      bit done = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bready && bvalid) begin
            bready <= 1'b0;
            done = 1;
            chk("bresp", er, bresp);
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      bit done = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rready && rvalid) begin
            rready <= 1'b0;
            done = 1;
            chk("rresp", er, rresp);
            chk("rdata", ed, rdata);
         end
      end
   endtask

   // Chosen source alone high, then all others high; idx 7 means muted
   task automatic route(input int ch, input int idx);
      logic [6:0] pat;
      pat = (idx == 7) ? 7'h7f : 7'h01 << idx;
      @(posedge aclk);
      srcs <= pat;
      repeat (10) @(posedge aclk);
      chk("div_clk", idx != 7, outs[ch]);
      srcs <= ~pat;
      repeat (10) @(posedge aclk);
      chk("div_clk", 0, outs[ch]);
      srcs <= 7'h00;
      repeat (3) @(posedge aclk);
   endtask

   // Source index for a code; pin fields set to pin zero on ch 1 and 3
   function automatic int exp_src(input int ch, input int code);
      int g;
      g = (ch % 2) ? 5 : 6;
      if (ch < 3)
         exp_src = (code < 5) ? code : (code == 5) ? g : 7;
      else
         exp_src = (code == 0) ? 0 : (code < 6) ? code - 1 :
                   (code == 6) ? g : 7;
   endfunction

   task automatic finish_test;
      if (num_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      logic [7:0]  a;
      logic [31:0] d;
      aclk = 0;
      aresetn = 0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
      srcs = 7'h00;
      auto_mode = 0;
      auto_ref = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_PD, 0, OK);
      rd(A_DO, 0, OK);
      rd(A_CP, 0, OK);
      rd(A_P1, 0, OK);
      rd(A_P2, 0, OK);
      rd(8'h00, 0, `CSEL_RESP_SLVERR);
      wr(8'h48, 32'h0000_00ff, 4'hf, `CSEL_RESP_SLVERR);
      wr(A_CP, 32'h0000_0005, 4'h0, OK);
      rd(A_CP, 0, OK);
      wr(A_CP, 32'habcd_12ff, 4'hf, OK);
      rd(A_CP, 32'h0000_00ff, OK);
      wr(A_P1, 32'h0000_0035, 4'hf, OK);
      wr(A_P2, 32'h0000_0053, 4'hf, OK);
      wr(A_PD, 32'h0000_0000, 4'hf, OK);
      route(0, 3);
      wr(A_PD, 32'h0000_0010, 4'hf, OK);
      route(0, 4);
      auto_mode <= 1'b1;
      route(0, 3);
      auto_ref <= 1'b1;
      wr(A_PD, 32'h0000_0000, 4'hf, OK);
      route(0, 4);
      auto_mode <= 1'b0;
      route(0, 3);
      // All selector codes
      for (int ch = 1; ch < 5; ch++) begin
         for (int code = 0; code < 8; code++) begin
            a = (ch == 1) ? A_PD : (ch == 4) ? A_CP : A_DO;
            d = 32'(code) << ((ch == 2) ? 4 : 0);
            wr(a, d, 4'hf, OK);
            rd(a, d, OK);
            route(ch, exp_src(ch, code));
         end
      end
      // Reserved pin code mutes
      wr(A_DO, 32'h0000_0050, 4'hf, OK);
      wr(A_P1, 32'h0000_0032, 4'hf, OK);
      route(2, 7);
      wr(A_DO, 32'h0000_0010, 4'hf, OK);
      @(posedge aclk);
      srcs <= 7'h02;
      repeat (10) @(posedge aclk);
      chk("div_clk", 1, outs[2]);
      srcs <= 7'h0a;
      wr(A_DO, 32'h0000_0030, 4'hf, OK);
      repeat (6) @(posedge aclk);
      chk("div_clk", 1, outs[2]);
      srcs <= 7'h08;
      repeat (4) @(posedge aclk);
      chk("div_clk", 0, outs[2]);
      repeat (10) @(posedge aclk);
      chk("div_clk", 1, outs[2]);
      rd(8'h80, 32'h0000_000d, OK);
      finish_test;
   end

   // Hang guard, far above the run length
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      finish_test;
   end
endmodule // csel_top_tb_top
